/* File: stp_defines.svh */
// constants of the two-wire target register port
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH
`define STP_CLK_HZ    50000000
`define STP_TMO_MS    30
`define STP_TMO_CYC   (`STP_TMO_MS * (`STP_CLK_HZ / 1000))
`define STP_IDLE_US   150
`define STP_IDLE_CYC  (`STP_IDLE_US * (`STP_CLK_HZ / 1000000))
`define STP_ADDR_V1   7'h4C
`define STP_ADDR_V2   7'h4D
`define STP_PTR_RST   8'h00
`define STP_BYTE_BITS 4'h8
`endif

/* File: stp_pkg.sv */
// types of the two-wire target register port
package stp_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_ACK_A = 8'h04,
    ST_WRX   = 8'h08,
    ST_ACK_W = 8'h10,
    ST_TX    = 8'h20,
    ST_ACK_H = 8'h40,
    ST_HOLD  = 8'h80
  } stp_state_e;
endpackage

/* File: stp_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module stp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage; reset shows released lines
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // stp_sync
`default_nettype wire

/* File: stp_target.sv */
// two-wire target port with auto-incrementing register pointer
// Behaviour
// - never pull the clock line low
// - data falling while clock high starts; a start after lines high 150 us outside standby is lost to the idle reset
// - first byte: seven address bits, direction
// - answer only own variant address
// - acknowledge every received byte low
// - eight bits per byte, msb first
// - data rising while clock high resets
// - enabled 30 ms clock low resets
// - lines high 150 us resets outside standby
// - write byte stores data at register
// - block write increments pointer, wraps, unbounded
// - read byte after pointer set, repeated start
// - block read advances on host ack
// - send byte loads pointer only
// - receive byte reads current pointer
// - reserved bits read as zero
`timescale 1ns/10ps
`default_nettype none
`include "stp_defines.svh"
module stp_target #(
  parameter int TMO_CYC  = `STP_TMO_CYC,
  parameter int IDLE_CYC = `STP_IDLE_CYC
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       CE_I,
  input  wire logic       SERIAL_CLOCK_PIN_I,
  input  wire logic       SDA_I,
  input  wire logic       VARIANT_SEL_I,
  input  wire logic       TIMEOUT_EN_I,
  input  wire logic       STANDBY_I,
  input  wire logic [7:0] REG_RDATA_I,
  input  wire logic [7:0] REG_RSVD_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  output logic      [7:0] REG_PTR_O,
  output logic      [7:0] REG_WADDR_O,
  output logic      [7:0] REG_WDATA_O,
  output logic            REG_WE_O
);
  localparam int TW = $clog2(TMO_CYC + 1);
  localparam int IW = $clog2(IDLE_CYC + 1);

  // refuse counts the counters cannot serve
  if (TMO_CYC < 1 || IDLE_CYC < 1) begin : g_bad_cnt
    $error("stp_target: counts must be at least one");
  end

  stp_pkg::stp_state_e state_r;
  logic [2:0]    pin_s;
  logic          scl_q_r;
  logic          sda_q_r;
  logic [3:0]    cnt_r;
  logic [7:0]    shreg_r;
  logic          dir_r;
  logic          first_r;
  logic          hack_r;
  logic [TW-1:0] tmo_cnt_r;
  logic [IW-1:0] idle_cnt_r;

  // pins pass two flip-flops before any logic
  stp_sync #(.W(3)) u_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .d_i     ({SERIAL_CLOCK_PIN_I, SDA_I, VARIANT_SEL_I}),
    .q_o     (pin_s)
  );

  // line events from synchronised levels
  wire       scl_s    = pin_s[2];
  wire       sda_s    = pin_s[1];
  wire       scl_hi   = scl_s & scl_q_r;
  wire       start_ev = scl_hi & sda_q_r & ~sda_s;
  wire       stop_ev  = scl_hi & ~sda_q_r & sda_s;
  wire       rise     = scl_s & ~scl_q_r;
  wire       fall     = ~scl_s & scl_q_r;
  wire       rx_done  = fall & (cnt_r == `STP_BYTE_BITS);
  wire [6:0] own_addr = pin_s[0] ? `STP_ADDR_V2 : `STP_ADDR_V1;
  wire       addr_ok  = (shreg_r[7:1] == own_addr);
  wire [7:0] rd_byte  = REG_RDATA_I & ~REG_RSVD_I;
  wire       tmo_hit  = TIMEOUT_EN_I & (tmo_cnt_r == TW'(TMO_CYC));
  wire       idle_hit = ~STANDBY_I & (idle_cnt_r == IW'(IDLE_CYC));
  wire       bus_rst  = stop_ev | tmo_hit | idle_hit;

  // previous line levels for edge detection
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (CE_I) begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // clock-low time-out counter, cleared while disabled
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      tmo_cnt_r <= '0;
    end else if (CE_I) begin
      if (scl_s || !TIMEOUT_EN_I || tmo_hit) begin
        tmo_cnt_r <= '0;
      end else begin
        tmo_cnt_r <= TW'(tmo_cnt_r + 1'b1);
      end
    end
  end

  // both-lines-high idle counter, saturating
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      idle_cnt_r <= '0;
    end else if (CE_I) begin
      if (!(scl_s && sda_s) || STANDBY_I) begin
        idle_cnt_r <= '0;
      end else if (idle_cnt_r != IW'(IDLE_CYC)) begin
        idle_cnt_r <= IW'(idle_cnt_r + 1'b1);
      end
    end
  end

  // open-drain data: the pin only ever pulls low
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      SDA_O <= 1'b0;
    end else if (CE_I) begin
      SDA_O <= 1'b0;
    end
  end

  // protocol engine; data changes only on clock falls and on the clock-low time-out
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state_r     <= stp_pkg::ST_IDLE;
      cnt_r       <= 4'h0;
      shreg_r     <= 8'h00;
      dir_r       <= 1'b0;
      first_r     <= 1'b0;
      hack_r      <= 1'b0;
      SDA_OE_O    <= 1'b0;
      REG_PTR_O   <= `STP_PTR_RST;
      REG_WADDR_O <= 8'h00;
      REG_WDATA_O <= 8'h00;
      REG_WE_O    <= 1'b0;
    end else if (CE_I) begin
      REG_WE_O <= 1'b0;
      if (bus_rst) begin
        state_r  <= stp_pkg::ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else if (start_ev) begin
        state_r  <= stp_pkg::ST_ADDR;
        cnt_r    <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else begin
        case (state_r)
          stp_pkg::ST_ADDR, stp_pkg::ST_WRX: begin
            if (rise) begin
              shreg_r <= {shreg_r[6:0], sda_s};
              cnt_r   <= 4'(cnt_r + 4'h1);
            end else if (rx_done && state_r == stp_pkg::ST_ADDR) begin
              if (addr_ok) begin
                SDA_OE_O <= 1'b1;
                dir_r    <= shreg_r[0];
                first_r  <= 1'b1;
                state_r  <= stp_pkg::ST_ACK_A;
              end else begin
                state_r <= stp_pkg::ST_HOLD;
              end
            end else if (rx_done) begin
              SDA_OE_O <= 1'b1;
              first_r  <= 1'b0;
              state_r  <= stp_pkg::ST_ACK_W;
              if (first_r) begin
                REG_PTR_O <= shreg_r;
              end else begin
                REG_WE_O    <= 1'b1;
                REG_WADDR_O <= REG_PTR_O;
                REG_WDATA_O <= shreg_r;
                REG_PTR_O   <= 8'(REG_PTR_O + 8'h01);
              end
            end
          end
          stp_pkg::ST_ACK_A: begin
            if (fall) begin
              cnt_r <= 4'h0;
              if (dir_r) begin
                shreg_r  <= rd_byte;
                SDA_OE_O <= ~rd_byte[7];
                state_r  <= stp_pkg::ST_TX;
              end else begin
                SDA_OE_O <= 1'b0;
                state_r  <= stp_pkg::ST_WRX;
              end
            end
          end
          stp_pkg::ST_ACK_W: begin
            if (fall) begin
              SDA_OE_O <= 1'b0;
              cnt_r    <= 4'h0;
              state_r  <= stp_pkg::ST_WRX;
            end
          end
          stp_pkg::ST_TX: begin
            if (rise) begin
              cnt_r <= 4'(cnt_r + 4'h1);
            end else if (rx_done) begin
              SDA_OE_O <= 1'b0;
              state_r  <= stp_pkg::ST_ACK_H;
            end else if (fall) begin
              shreg_r  <= {shreg_r[6:0], 1'b0};
              SDA_OE_O <= ~shreg_r[6];
            end
          end
          stp_pkg::ST_ACK_H: begin
            if (rise) begin
              hack_r <= ~sda_s;
              if (!sda_s) begin
                REG_PTR_O <= 8'(REG_PTR_O + 8'h01);
              end
            end else if (fall) begin
              if (hack_r) begin
                cnt_r    <= 4'h0;
                shreg_r  <= rd_byte;
                SDA_OE_O <= ~rd_byte[7];
                state_r  <= stp_pkg::ST_TX;
              end else begin
                state_r <= stp_pkg::ST_HOLD;
              end
            end
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  // checks on the protocol engine
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  wire go = CE_I & ~bus_rst & ~start_ev;

  sequence s_addr_match;
    go && state_r == stp_pkg::ST_ADDR && rx_done && addr_ok;
  endsequence
  sequence s_addr_miss;
    go && state_r == stp_pkg::ST_ADDR && rx_done && !addr_ok;
  endsequence

  property p_start;
    CE_I && start_ev && !bus_rst |=> state_r == stp_pkg::ST_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  property p_stop;
    CE_I && stop_ev |=> state_r == stp_pkg::ST_IDLE && !SDA_OE_O;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");

  property p_ack_addr;
    s_addr_match |=> SDA_OE_O && state_r == stp_pkg::ST_ACK_A;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("no addr ack");

  property p_miss;
    s_addr_miss |=> !SDA_OE_O && state_r == stp_pkg::ST_HOLD;
  endproperty
  a_miss: assert property (p_miss) else $error("foreign addr acked");

  property p_tmo;
    CE_I && tmo_hit |=> state_r == stp_pkg::ST_IDLE;
  endproperty
  a_tmo: assert property (p_tmo) else $error("time-out ignored");

  property p_idle;
    CE_I && idle_hit |=> state_r == stp_pkg::ST_IDLE && !SDA_OE_O;
  endproperty
  a_idle: assert property (p_idle) else $error("idle ignored");

  property p_oe_low;
    $rose(SDA_OE_O) |-> !scl_s;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("drive on clk high");

  property p_we;
    REG_WE_O && CE_I |-> REG_PTR_O == 8'(REG_WADDR_O + 8'h01) ##1 !REG_WE_O;
  endproperty
  a_we: assert property (p_we) else $error("bad write pointer");

  property p_hack;
    go && state_r == stp_pkg::ST_ACK_H && rise && !sda_s
      |=> REG_PTR_O == 8'($past(REG_PTR_O) + 8'h01);
  endproperty
  a_hack: assert property (p_hack) else $error("read ptr stuck");

  property p_send;
    go && state_r == stp_pkg::ST_WRX && rx_done && first_r
      |=> REG_PTR_O == $past(shreg_r) && !REG_WE_O;
  endproperty
  a_send: assert property (p_send) else $error("ptr load failed");

  property p_msb;
    go && state_r == stp_pkg::ST_TX && fall && !rx_done
      |=> SDA_OE_O == !$past(shreg_r[6]);
  endproperty
  a_msb: assert property (p_msb) else $error("bit order wrong");
endmodule // stp_target
`default_nettype wire

/* File: stp_host.sv */
// host controller model driving the two bus lines
`timescale 1ns/10ps
`default_nettype none
module stp_host #(
  parameter int Q = 8
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // both lines released at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one phase of the bus clock
  task automatic half();
    repeat (Q) @(posedge clk_i);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b1;
    half();
  endtask
  // one bit: data set while clock low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
    half();
  endtask
  // one data-high bit whose clock-high phase lasts n system clocks
  task automatic slow_bit(input int n);
    sda_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    scl_o <= 1'b0;
    half();
  endtask
  // one byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ab, ak);
  endtask
endmodule // stp_host
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench of the two-wire target port
`timescale 1ns/10ps
`default_nettype none
`include "stp_defines.svh"
module tb_top;
  logic       clk, rst_n, var_sel, tmo_en, stby, sda_o, oe, we, oe_q, ak;
  logic [7:0] rsvd, ptr, waddr, wdata, q;
  logic [7:0] mem [256];
  logic [7:0] em  [256];
  logic [7:0] eptr;
  logic [6:0] own_a;
  wire  logic scl, hsda, sda;
  int         errors, checks, cyc, seed;
  // open-drain data line with pull-up; clock only from the host
  assign sda = hsda & ~(oe & ~sda_o);
  assign own_a = var_sel ? `STP_ADDR_V2 : `STP_ADDR_V1;
  stp_target #(.TMO_CYC(200), .IDLE_CYC(100)) u_stp_target (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .SERIAL_CLOCK_PIN_I(scl), .SDA_I(sda), .VARIANT_SEL_I(var_sel),
    .TIMEOUT_EN_I(tmo_en), .STANDBY_I(stby), .REG_RDATA_I(mem[ptr]),
    .REG_RSVD_I(rsvd), .SDA_O(sda_o), .SDA_OE_O(oe), .REG_PTR_O(ptr),
    .REG_WADDR_O(waddr), .REG_WDATA_O(wdata), .REG_WE_O(we));
  stp_host u_stp_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // register file outside the port
  always @(posedge clk) if (we === 1'b1) mem[waddr] <= wdata;
  task automatic check(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected read byte: reserved bits come back as zero
  function automatic logic [7:0] exp_rd(input logic [7:0] v, m);
    return v & ~m;
  endfunction
  task automatic conclude();
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // data drive changes only while the clock is low; hang limit
  always @(posedge clk) begin
    oe_q <= oe;
    cyc++;
    if (rst_n === 1'b1 && scl === 1'b1)
      check("oe_steady", {7'h00, oe}, {7'h00, oe_q});
    if (rst_n === 1'b1 && oe === 1'b1)
      check("sda_low", {7'h00, sda_o}, 8'h00);
    if (cyc == 80000) begin
      errors++;
      conclude();
    end
  end
  // write direction: pointer byte then n data bytes
  task automatic bwr(input logic [6:0] a, input logic [7:0] p,
                     input int n, input logic stp);
    logic [7:0] d;
    logic       own;
    own = (a == own_a);
    stby <= 1'($random(seed));
    u_stp_host.start();
    u_stp_host.xfer({a, 1'b0}, 1'b1, q, ak);
    check("addr_ack", {7'h00, ak}, {7'h00, ~own});
    u_stp_host.xfer(p, 1'b1, q, ak);
    check("ptr_ack", {7'h00, ak}, {7'h00, ~own});
    if (own)
      eptr = p;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      u_stp_host.xfer(d, 1'b1, q, ak);
      check("data_ack", {7'h00, ak}, {7'h00, ~own});
      if (own) begin
        em[eptr] = d;
        eptr++;
      end
    end
    if (stp)
      u_stp_host.stop();
    check("ptr", ptr, eptr);
  endtask
  // read direction: n bytes, host acks all but the last
  task automatic brd(input int n);
    rsvd <= 8'($random(seed));
    u_stp_host.start();
    u_stp_host.xfer({own_a, 1'b1}, 1'b1, q, ak);
    check("raddr_ack", {7'h00, ak}, 8'h00);
    for (int i = 0; i < n; i++) begin
      u_stp_host.xfer(8'hFF, i == n - 1, q, ak);
      check("rdata", q, exp_rd(em[eptr], rsvd));
      if (i < n - 1)
        eptr++;
    end
    u_stp_host.stop();
    check("rptr", ptr, eptr);
  endtask
  // main sequence
  initial begin
    seed = 32'h837F7445;
    {rst_n, var_sel, tmo_en, stby, rsvd} = '0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      em[i] = mem[i];
    end
    eptr = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("ptr_reset", ptr, 8'h00);
    for (int v = 0; v < 2; v++) begin
      var_sel <= v[0];
      repeat (4) @(posedge clk);
      bwr(own_a, 8'($random(seed)), 1, 1'b1);
      bwr(own_a ^ 7'h01, 8'h10, 2, 1'b1);
      bwr(own_a, 8'hFE, 3, 1'b1);
      bwr(own_a, 8'($random(seed)), 0, 1'b0);
      brd(1);
      brd(1);
      bwr(own_a, 8'hFF, 0, 1'b1);
      brd(3);
      repeat (4) bwr(own_a, 8'($random(seed)), $random(seed) & 3, 1'b1);
      brd(4);
    end
    // partial byte cut by a stop changes nothing
    u_stp_host.start();
    u_stp_host.xfer({own_a, 1'b0}, 1'b1, q, ak);
    for (int i = 0; i < 4; i++)
      u_stp_host.bit_x(1'b1, ak);
    u_stp_host.stop();
    check("ptr_abort", ptr, eptr);
    brd(1);
    // clock held low inside the acknowledge, time-out off then on
    u_stp_host.start();
    for (int i = 7; i >= 0; i--)
      u_stp_host.bit_x(i == 0 ? 1'b0 : own_a[i - 1], ak);
    repeat (300) @(posedge clk);
    check("oe_no_tmo", {7'h00, oe}, 8'h01);
    tmo_en <= 1'b1;
    repeat (250) @(posedge clk);
    check("oe_tmo", {7'h00, oe}, 8'h00);
    tmo_en <= 1'b0;
    u_stp_host.stop();
    brd(2);
    // long clock-high phase: idle resets unless in standby
    for (int s = 0; s < 2; s++) begin
      stby <= s[0];
      u_stp_host.start();
      u_stp_host.xfer({own_a, 1'b0}, 1'b1, q, ak);
      check("idle_addr_ack", {7'h00, ak}, 8'h00);
      u_stp_host.slow_bit(150);
      for (int i = 6; i >= 0; i--)
        u_stp_host.bit_x(i[0], ak);
      u_stp_host.bit_x(1'b1, ak);
      check("idle_ack", {7'h00, ak}, {7'h00, ~s[0]});
      u_stp_host.stop();
      if (s[0])
        eptr = 8'hAA;
      check("idle_ptr", ptr, eptr);
    end
    for (int i = 0; i < 256; i++)
      check("reg", mem[i], em[i]);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
